// [rtl/mss_startup.v]
`timescale 1ns/10ps
`include "mss_defs.vh"

module mss_startup (
	// Clock and reset
	input wire core_clk_i,
	input wire rst_n_i,
	// Avalon-MM slave
	input wire [3:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	output reg [31:0] avs_readdata_o,
	output wire avs_waitrequest_o,
	// Motor sense pins
	input wire back_emf_spinning_i,
	input wire back_emf_forward_i,
	input wire back_emf_above_thr_i,
	input wire rotor_aligned_i,
	// Phase drive
	output reg [2:0] high_side_on_o,
	output reg [2:0] low_side_on_o,
	output reg [2:0] phase_float_o,
	output reg [1:0] phase_mode_o,
	output reg closed_loop_o,
	output reg [10:0] back_emf_magnitude_o
);

	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	localparam ST_IDLE = 4'd0;
	localparam ST_DETECT = 4'd1;
	localparam ST_CLASSIFY = 4'd2;
	localparam ST_REVERSE = 4'd3;
	localparam ST_BRAKE = 4'd4;
	localparam ST_COAST = 4'd5;
	localparam ST_IPD = 4'd6;
	localparam ST_ALIGN = 4'd7;
	localparam ST_ACCEL = 4'd8;
	localparam ST_CLOSED = 4'd9;

	localparam MOT_STOP = 2'd0;
	localparam MOT_FWD = 2'd1;
	localparam MOT_REV = 2'd2;

	localparam [15:0] SETTLE_CYC = `MSS_SETTLE_CYC;
	localparam [15:0] QUIET_CYC = `MSS_STOP_QUIET_CYC;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	wire [3:0] pin_raw = {rotor_aligned_i, back_emf_above_thr_i, back_emf_forward_i, back_emf_spinning_i};
	wire [3:0] pin_s;
	wire spin_s = pin_s[0];
	wire fwd_s = pin_s[1];
	wire fast_s = pin_s[2];
	wire aligned_s = pin_s[3];

	// Two flops per pin; only the second stage is read
	genvar pin;
	generate
		for (pin = 0; pin < 4; pin = pin + 1) begin : g_sync
			reg stage_a;
			reg stage_b;
			always @(posedge core_clk_i) begin
				if (!rst_n_i) begin
					stage_a <= 1'b0;
					stage_b <= 1'b0;
				end else begin
					stage_a <= pin_raw[pin];
					stage_b <= stage_a;
				end
			end
			assign pin_s[pin] = stage_b;
		end
	endgenerate

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	reg [4:0] ctrl;
	reg [6:0] back_emf_constant_code;
	reg [3:0] state;
	reg [1:0] motion;
	reg [15:0] timer;
	reg start_pulse;
	reg rd_done;

	wire [2:0] back_emf_constant_shift = back_emf_constant_code[`MSS_BACK_EMF_SHIFT_MSB:`MSS_BACK_EMF_SHIFT_LSB];
	wire [3:0] back_emf_constant_mantissa = back_emf_constant_code[`MSS_BACK_EMF_MANT_MSB:0];
	// Largest is 15 << 7 = 1920 at code 0x7F, smallest 0 at 0x00, smallest nonzero 1 at 0x01
	wire [10:0] next_magnitude = {7'h00, back_emf_constant_mantissa} << back_emf_constant_shift;

	// Single wait state on reads so the read data comes from a flop
	assign avs_waitrequest_o = avs_read_i & ~rd_done;

	// ------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------
	wire rd_take = avs_read_i & ~rd_done;
	reg [31:0] next_readdata;

	always @* begin
		case (avs_address_i)
			`MSS_REG_CTRL: next_readdata = {27'h000_0000, ctrl};
			`MSS_REG_BACK_EMF: next_readdata = {25'h000_0000, back_emf_constant_code};
			`MSS_REG_STAT: next_readdata = {25'h000_0000, closed_loop_o, motion, state};
			`MSS_REG_MAG: next_readdata = {21'h00_0000, next_magnitude};
			default: next_readdata = 32'h0000_0000;
		endcase
	end

	always @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ctrl <= 5'h00;
			back_emf_constant_code <= `MSS_BACK_EMF_RESET;
			start_pulse <= 1'b0;
			rd_done <= 1'b0;
			avs_readdata_o <= 32'h0000_0000;
			back_emf_magnitude_o <= 11'h000;
		end else begin
			start_pulse <= 1'b0;
			back_emf_magnitude_o <= next_magnitude;
			rd_done <= rd_take;
			if (avs_write_i) begin
				case (avs_address_i)
					`MSS_REG_CTRL: begin
						ctrl <= {avs_writedata_i[4:1], 1'b0};
						start_pulse <= avs_writedata_i[`MSS_CTRL_START];
					end
					`MSS_REG_BACK_EMF: begin
						back_emf_constant_code <= avs_writedata_i[6:0];
					end
					default: begin
					end
				endcase
			end
			if (rd_take) begin
				avs_readdata_o <= next_readdata;
			end
		end
	end

	// ------------------------------------------------------------
	// Start-up sequencer
	// ------------------------------------------------------------
	reg [3:0] next_state;
	reg [1:0] next_motion;
	wire timer_done = (timer == 16'h0000);
	reg [1:0] sensed_motion;
	reg [15:0] next_timer;
	wire quiet_wait = (next_state == ST_BRAKE) || (next_state == ST_COAST);

	always @* begin
		if (!spin_s)
			sensed_motion = MOT_STOP;
		else if (fwd_s)
			sensed_motion = MOT_FWD;
		else
			sensed_motion = MOT_REV;
	end

	always @* begin
		if (next_state != state)
			next_timer = quiet_wait ? QUIET_CYC : SETTLE_CYC;
		else if (quiet_wait && spin_s)
			next_timer = QUIET_CYC; // Stop needs an unbroken quiet spell
		else if (!timer_done)
			next_timer = timer - 16'h0001;
		else
			next_timer = timer;
	end

	always @* begin
		next_state = state;
		next_motion = motion;
		case (state)
			ST_IDLE: begin
				if (start_pulse) begin
					next_state = ctrl[`MSS_CTRL_SPD_DET_EN] ? ST_DETECT : ST_CLASSIFY;
					next_motion = MOT_STOP;
				end
			end
			ST_DETECT: begin
				if (timer_done) begin
					next_state = ST_CLASSIFY;
					next_motion = sensed_motion;
				end
			end
			ST_CLASSIFY: begin
				case (motion)
					MOT_FWD: begin
						// Too slow to lock: treat as stationary path
						if (fast_s)
							next_state = ST_CLOSED;
						else
							next_state = ctrl[`MSS_CTRL_IPD_EN] ? ST_IPD : ST_ALIGN;
					end
					MOT_REV: begin
						if (ctrl[`MSS_CTRL_RVS_EN])
							next_state = ST_REVERSE;
						else if (ctrl[`MSS_CTRL_BRK_EN])
							next_state = ST_BRAKE;
						else
							next_state = ST_COAST;
					end
					default: begin
						next_state = ctrl[`MSS_CTRL_IPD_EN] ? ST_IPD : ST_ALIGN;
					end
				endcase
			end
			ST_REVERSE: begin
				if (!spin_s || fwd_s)
					next_state = ST_ACCEL;
			end
			ST_BRAKE, ST_COAST: begin
				if (timer_done) begin
					next_motion = MOT_STOP;
					next_state = ctrl[`MSS_CTRL_IPD_EN] ? ST_IPD : ST_ALIGN;
				end
			end
			ST_IPD: begin
				if (timer_done)
					next_state = ST_ACCEL;
			end
			ST_ALIGN: begin
				if (timer_done && aligned_s)
					next_state = ST_ACCEL;
			end
			ST_ACCEL: begin
				if (fast_s)
					next_state = ST_CLOSED;
			end
			ST_CLOSED: begin
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state <= ST_IDLE;
			motion <= MOT_STOP;
			timer <= 16'h0000;
		end else begin
			state <= next_state;
			motion <= next_motion;
			timer <= next_timer;
		end
	end

	// ------------------------------------------------------------
	// Phase drive outputs
	// ------------------------------------------------------------
	reg [2:0] next_high;
	reg [2:0] next_low;
	reg [2:0] next_float;
	reg [1:0] next_mode;
	wire [2:0] leg_guard;

	always @* begin
		next_high = 3'b000;
		next_low = 3'b000;
		next_float = 3'b111;
		next_mode = 2'd0;
		case (next_state)
			ST_BRAKE: begin
				next_low = 3'b111;
				next_float = 3'b000;
			end
			ST_ALIGN: begin
				// Current into V, out of W
				next_high = 3'b010;
				next_low = 3'b100;
				next_float = 3'b001;
			end
			ST_IPD: begin
				next_mode = 2'd1;
				next_float = 3'b000;
			end
			ST_REVERSE, ST_ACCEL: begin
				next_mode = 2'd2;
				next_float = 3'b000;
			end
			ST_CLOSED: begin
				next_mode = 2'd3;
				next_float = 3'b000;
			end
			default: begin
			end
		endcase
	end

	// A leg whose switch swaps sides spends one cycle with both off
	genvar leg;
	generate
		for (leg = 0; leg < 3; leg = leg + 1) begin : g_leg
			assign leg_guard[leg] = ~((high_side_on_o[leg] & next_low[leg]) | (low_side_on_o[leg] & next_high[leg]));
		end
	endgenerate

	// ------------------------------------------------------------
	// Drive registers
	// ------------------------------------------------------------
	always @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			high_side_on_o <= 3'b000;
			low_side_on_o <= 3'b000;
			phase_float_o <= 3'b111;
			phase_mode_o <= 2'd0;
			closed_loop_o <= 1'b0;
		end else begin
			high_side_on_o <= next_high & leg_guard;
			low_side_on_o <= next_low & leg_guard;
			phase_float_o <= next_float;
			phase_mode_o <= next_mode;
			closed_loop_o <= (next_state == ST_CLOSED);
		end
	end

endmodule

// [rtl/mss_defs.vh]
// Behaviour
// - Back-EMF constant is a 7-bit code: 3-bit shift above 4-bit mantissa.
// - Decoded magnitude is mantissa shifted left by the shift field.
// - Code 0x7F decodes to 1920, about 1760 mV/Hz.
// - Code 0x01 decodes to one, 0.92 mV/Hz per step.
// - Stationary motor is aligned by inductive detect or forced alignment.
// - Inductive detect finds rotor angle from winding inductance variation.
// - Forced alignment drives a chosen phase so the rotor lines up.
// - Forward spinning motor above threshold resynchronises straight into closed loop.
// - Reverse drive decelerates a reverse motor through zero into forward acceleration.
// - Without reverse drive, a reverse motor is coasted to stop or braked.
// - After a coasted or braked reverse motor stops, start-up continues as for a stationary motor.
// - Brake turns on all three low-side drivers, shorting the windings.
`ifndef MSS_DEFS_VH
`define MSS_DEFS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define MSS_REG_CTRL 4'h0
`define MSS_REG_BACK_EMF 4'h4
`define MSS_REG_STAT 4'h8
`define MSS_REG_MAG 4'hC

// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define MSS_CTRL_START 0
`define MSS_CTRL_SPD_DET_EN 1
`define MSS_CTRL_IPD_EN 2
`define MSS_CTRL_RVS_EN 3
`define MSS_CTRL_BRK_EN 4
`define MSS_CTRL_RESET 32'h0000_0000

// ------------------------------------------------------------
// Code fields
// ------------------------------------------------------------
`define MSS_BACK_EMF_SHIFT_MSB 6
`define MSS_BACK_EMF_SHIFT_LSB 4
`define MSS_BACK_EMF_MANT_MSB 3
`define MSS_BACK_EMF_RESET 7'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
// Settle 100 us and quiet stop 150 us at 20 MHz
`define MSS_SETTLE_CYC 16'h07D0
`define MSS_STOP_QUIET_CYC 16'h0BB8

`endif

// [tb/mss_startup_asserts.sv]
`timescale 1ns/10ps
module mss_startup_asserts (
	input wire core_clk_i,
	input wire rst_n_i,
	input wire [3:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire avs_waitrequest_o,
	input wire [2:0] high_side_on_o,
	input wire [2:0] low_side_on_o,
	input wire [2:0] phase_float_o,
	input wire [1:0] phase_mode_o,
	input wire closed_loop_o,
	input wire [10:0] back_emf_magnitude_o
);
	reg [10:0] exp_mag;
	wire wr_code = avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h4;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	always @(posedge core_clk_i) begin
		if (!rst_n_i)
			exp_mag <= 11'h000;
		else if (wr_code)
			exp_mag <= {7'h00, avs_writedata_i[3:0]} << avs_writedata_i[6:4];
	end
	chk_leg_short: assert property ((high_side_on_o & low_side_on_o) == 3'h0) else $error("leg short");
	chk_float_idle: assert property ((phase_float_o & (high_side_on_o | low_side_on_o)) == 3'h0) else $error("float");
	chk_mag_max: assert property (back_emf_magnitude_o <= 11'h780) else $error("magnitude high");
	chk_mag_decode: assert property (wr_code |=> ##[0:1] back_emf_magnitude_o == exp_mag) else $error("decode");
	chk_closed_mode: assert property (closed_loop_o |-> phase_mode_o == 2'h3) else $error("closed mode");
	chk_closed_hold: assert property (closed_loop_o |=> closed_loop_o) else $error("closed dropped");
	chk_read_wait: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("wait");
	chk_reset_idle: assert property ($rose(rst_n_i) |-> phase_mode_o == 2'h0 && phase_float_o == 3'h7) else $error("idle");
endmodule
bind mss_startup mss_startup_asserts u_chk (.*);

// [tb/mss_motor.sv]
`timescale 1ns/10ps
module mss_motor (
	// Clock and wanted motion: 0 still, 1 forward, 2 reverse
	input wire core_clk_i,
	input wire [1:0] spin_i,
	// Phase drive
	input wire [2:0] high_side_on_i,
	input wire [2:0] low_side_on_i,
	// Sense lines
	output wire spinning_o,
	output wire forward_o,
	output wire aligned_o
);
	reg [7:0] brk_cnt = 8'h00;
	reg [5:0] drv_cnt = 6'h00;
	reg stopped = 1'b0;
	always @(posedge core_clk_i) begin
		brk_cnt <= (low_side_on_i == 3'h7) ? brk_cnt + 8'h01 : 8'h00;
		stopped <= spin_i != 2'h0 && (stopped || brk_cnt == 8'hC8);
		drv_cnt <= (high_side_on_i == 3'h0) ? 6'h00 : drv_cnt + {5'h00, !aligned_o};
	end
	assign spinning_o = spin_i != 2'h0 && !stopped;
	assign forward_o = spin_i == 2'h1;
	assign aligned_o = &drv_cnt;
endmodule

// [tb/mss_startup_bench.sv]
`timescale 1ns/10ps
module mss_startup_bench;
	reg core_clk_i = 1'b0;
	reg rst_n_i = 1'b0;
	reg avs_read_i = 1'b0;
	reg avs_write_i = 1'b0;
	reg [3:0] avs_address_i = 4'h0;
	reg [31:0] avs_writedata_i = '0;
	reg [1:0] spin = 2'h0;
	reg [31:0] q;
	wire [31:0] avs_readdata_o;
	wire avs_waitrequest_o, back_emf_spinning_i, back_emf_forward_i, back_emf_above_thr_i, rotor_aligned_i;
	wire closed_loop_o;
	wire [2:0] high_side_on_o, low_side_on_o, phase_float_o;
	wire [1:0] phase_mode_o;
	wire [10:0] back_emf_magnitude_o;
	int errors = 0;
	int checked = 0;
	logic [6:0] code_t [4] = '{7'h7F, 7'h01, 7'h29, 7'h58};
	logic [10:0] mag_t [4] = '{11'h780, 11'h001, 11'h024, 11'h100};
	always #25 core_clk_i = !core_clk_i;
	mss_startup mss_startup_inst (.*);
	mss_motor mss_motor_inst (.core_clk_i, .spin_i(spin), .high_side_on_i(high_side_on_o),
		.low_side_on_i(low_side_on_o), .spinning_o(back_emf_spinning_i), .forward_o(back_emf_forward_i),
		.aligned_o(rotor_aligned_i));
	// Speed sense reads high whenever the rotor turns
	assign back_emf_above_thr_i = back_emf_spinning_i;
	task conclude;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		{avs_write_i, avs_read_i, avs_address_i, avs_writedata_i} <= {w, !w, a, d};
		n = 0;
		@(negedge core_clk_i);
		while (avs_waitrequest_o !== 1'b0 && n < 20) begin
			@(negedge core_clk_i);
			n++;
		end
		@(posedge core_clk_i);
		q = avs_readdata_o;
		{avs_write_i, avs_read_i} <= 2'h0;
		if (n == 20) begin
			errors++;
			conclude;
		end
		@(posedge core_clk_i);
	endtask
	task poll(input logic [3:0] s);
		q = '1;
		repeat (1500) if (q[3:0] !== s) bus(1'b0, 4'h8, '0);
		cmp("state", 32'(s), 32'(q[3:0]));
		if (q[3:0] !== s) conclude;
	endtask
	task launch(input logic [1:0] m, input logic [4:0] c, input logic [3:0] s);
		{rst_n_i, spin} <= 3'h0;
		repeat (10) @(posedge core_clk_i);
		{rst_n_i, spin} <= {1'b1, m};
		@(posedge core_clk_i);
		bus(1'b1, 4'h0, 32'(c));
		poll(s);
	endtask
	task t_regs;
		launch(2'h0, 5'h00, 4'h0);
		cmp("float", 32'h7, 32'(phase_float_o));
		bus(1'b0, 4'h2, '0);
		cmp("unmapped", '0, q);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 4'h4, 32'(code_t[i]));
			bus(1'b0, 4'hC, '0);
			cmp("mag", 32'(mag_t[i]), q);
			cmp("mag_out", 32'(mag_t[i]), 32'(back_emf_magnitude_o));
			bus(1'b0, 4'h4, '0);
			cmp("code", 32'(code_t[i]), q);
		end
		$display("regs done");
	endtask
	task t_ipd;
		launch(2'h0, 5'h05, 4'h6);
		cmp("mode", 32'h1, 32'(phase_mode_o));
		poll(4'h8);
		$display("ipd done");
	endtask
	task t_fwd;
		launch(2'h1, 5'h03, 4'h9);
		cmp("motion", 32'h1, 32'(q[5:4]));
		cmp("mode", 32'h3, 32'(phase_mode_o));
		cmp("closed", 32'h1, 32'(closed_loop_o));
		$display("resync done");
	endtask
	task t_brake;
		launch(2'h2, 5'h13, 4'h4);
		cmp("low", 32'h7, 32'(low_side_on_o));
		poll(4'h7);
		cmp("high", 32'h2, 32'(high_side_on_o));
		$display("brake done");
	endtask
	task t_coast;
		launch(2'h2, 5'h03, 4'h5);
		spin <= 2'h0;
		poll(4'h7);
		$display("coast done");
	endtask
	task t_rev;
		launch(2'h2, 5'h0B, 4'h3);
		cmp("motion", 32'h2, 32'(q[5:4]));
		spin <= 2'h0;
		poll(4'h8);
		$display("reverse done");
	endtask
	initial begin
		@(posedge core_clk_i);
		t_regs;
		t_ipd;
		t_fwd;
		t_brake;
		t_rev;
		t_coast;
		conclude;
	end
endmodule
